/* hw/drp_port.sv */
// Dynamic reconfiguration port: request handling, wait states and ready
`timescale 1ns/10ps
// How it works
// - Every port input except the asynchronous reset and the status word is sampled on the rising clock edge only.
// - Port signals active high except the active-low reset; bus bits numbered from zero upward.
// - Enable high starts a read when write enable low, else write.
// - With enable low, write enable, address and data are ignored.
// - Write data latched at request end, committed before ready.
// - Ready pulses for one cycle after each accepted request, after wait states; requests while busy get none.
// - Ready only answers an enabled request.
// - Read data is unregistered, valid only while ready is high.
// - Read data zero outside the ready cycle after a read.
// - Cells load CELL_RST (zero) at reset in place of bitstream values; config access port rewrites.
// - Each cell output drives the functional block logic directly.
// - Read-only status and write-only enables may share one address.
// - Port words are sixteen bits; partial updates read-modify-write.
module drp_port
    import drp_pkg::*;
#(
    parameter int WAITS = drp_pkg::WAIT_CYCLES
) (
    input  wire logic                          mclk_in,
    input  wire logic                          rst_b_in,
    input  wire drp_pkg::drp_req_t             req_in,
    input  wire logic                          cfg_ld_in,
    input  wire logic [drp_pkg::ADDR_W-1:0]    cfg_ldaddr_in,
    input  wire logic [drp_pkg::DATA_W-1:0]    cfg_lddata_in,
    input  wire logic [drp_pkg::DATA_W-1:0]    status_in,
    output logic      [drp_pkg::DATA_W-1:0]    rdata_out,
    output logic                               ready_out,
    output logic      [drp_pkg::DATA_W-1:0]    fn_enable_out,
    output logic [drp_pkg::NUM_CELLS*drp_pkg::DATA_W-1:0] cells_out
);
    import drp_pkg::*;

    // ****************************************
    // Request capture
    // ****************************************
    drp_state_t        state_ff;
    logic [CNT_W-1:0]  wait_ff;
    logic              we_ff;
    logic [ADDR_W-1:0] addr_ff;
    logic [DATA_W-1:0] wdata_ff;
    logic              ready_ff;
    logic [DATA_W-1:0] fn_en_ff;
    logic              commit;
    logic              accept;
    logic [DATA_W-1:0] cell_rd;
    logic [DATA_W-1:0] cell_bus_rd;

    // Last wait cycle: both the commit and the ready pulse key off it
    function automatic logic last_wait(input drp_state_t st, input logic [CNT_W-1:0] cnt);
        return (st == DRP_WAIT) && (cnt == '0);
    endfunction

    // Requests arriving while busy are dropped; the requester waits for ready
    assign accept = req_in.en && (state_ff == DRP_IDLE || state_ff == DRP_DONE);

    // Latch only with enable, so stray address or data never leak in
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            we_ff    <= 1'b0;
            addr_ff  <= '0;
            wdata_ff <= '0;
        end else if (accept) begin
            we_ff    <= req_in.we;
            addr_ff  <= req_in.addr;
            wdata_ff <= req_in.wdata;
        end
    end

    // ****************************************
    // Sequencing
    // ****************************************
    // Idle -> wait states -> done (ready) ; done may accept the next request
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_ff <= DRP_IDLE;
            wait_ff  <= '0;
        end else begin
            unique case (state_ff)
                DRP_IDLE, DRP_DONE: begin
                    if (accept) begin
                        state_ff <= DRP_WAIT;
                        // Load one short so zero is the last wait; WAITS below one would wrap
                        wait_ff  <= CNT_W'(WAITS - 1);
                    end else begin
                        state_ff <= DRP_IDLE;
                    end
                end
                DRP_WAIT: begin
                    if (wait_ff == '0) state_ff <= DRP_DONE;
                    else wait_ff <= wait_ff - 1'b1;
                end
                // Stray code falls back to idle rather than hanging the port
                default: state_ff <= DRP_IDLE;
            endcase
        end
    end

    // Commit the write in the last wait cycle, just before ready
    assign commit = last_wait(state_ff, wait_ff) && we_ff;

    // Ready is a single registered pulse per accepted request
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) ready_ff <= 1'b0;
        else ready_ff <= last_wait(state_ff, wait_ff);
    end

    // Write-only enable word shares the status address
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) fn_en_ff <= '0;
        else if (commit && addr_ff == ENABLE_ADDR) fn_en_ff <= wdata_ff;
    end

    // ****************************************
    // Cell array
    // ****************************************
    drp_cells u_cells (
        .mclk_in   (mclk_in),
        .rst_b_in  (rst_b_in),
        .wr_in     (commit && addr_ff != ENABLE_ADDR),
        .waddr_in  (addr_ff),
        .wdata_in  (wdata_ff),
        .ld_in     (cfg_ld_in),
        .ldaddr_in (cfg_ldaddr_in),
        .lddata_in (cfg_lddata_in),
        .raddr_in  (addr_ff),
        .rdata_out (cell_bus_rd),
        .cells_out (cells_out)
    );

    // Status read-only at the shared address; zero outside a read's ready cycle
    always_comb begin
        cell_rd = (addr_ff == STATUS_ADDR) ? status_in : cell_bus_rd;
        rdata_out = (ready_ff && !we_ff) ? cell_rd : '0;
    end

    assign ready_out     = ready_ff;
    assign fn_enable_out = fn_en_ff;

    // ****************************************
    // Checks
    // ****************************************
    // Latencies are written out for the default of two wait states
    sequence s_req;
        accept;
    endsequence
    sequence s_done;
        ##(WAIT_CYCLES+1) ready_out;
    endsequence
    sequence s_quiet;
        !ready_out [*2];
    endsequence

    // Request to ready: two quiet wait cycles, then the pulse
    a_ready_after_req: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        s_req |-> ##1 s_quiet ##1 ready_out)
        else $error("ready not at fixed latency");

    // A pulse not followed by a new request drops at once
    a_ready_one_cycle: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        ready_out && !accept |=> !ready_out)
        else $error("ready longer than one cycle");

    // No pulse without a request three edges earlier
    a_ready_has_cause: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        ready_out |-> $past(accept, 3))
        else $error("ready without request");

    // Zero outside the ready cycle keeps stale cells off the bus
    a_data_idle_zero: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        !ready_out |-> rdata_out == '0)
        else $error("read data outside ready");

    // Write data is caught at the end of the request cycle
    a_write_latched: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        accept && req_in.we |=> we_ff && wdata_ff == $past(req_in.wdata))
        else $error("write data not latched");

    // The cell write happens before ready announces it
    a_commit_before_rdy: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        commit |=> ready_out)
        else $error("commit not before ready");

    // Lines without enable leave the captured request alone
    a_idle_ignore: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        !req_in.en && state_ff == DRP_IDLE |=> $stable(addr_ff) && $stable(wdata_ff))
        else $error("inputs taken without enable");

    // A read never turns into a write on its way to ready
    a_read_no_write: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        accept && !req_in.we |-> s_done ##0 !we_ff)
        else $error("read treated as write");

    // Read data is the addressed cell, checked against the cell outputs
    a_read_cell: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        ready_out && !we_ff && addr_ff != STATUS_ADDR
        |-> rdata_out == cells_out[addr_ff*DATA_W +: DATA_W])
        else $error("read data not the addressed cell");

    // The status word, not a cell, answers reads of the shared address
    a_status_shared: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        ready_out && !we_ff && addr_ff == STATUS_ADDR |-> rdata_out == status_in)
        else $error("status word not shown on read");

    // Writes to the shared address reach only the enable word
    a_enable_word: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        commit && addr_ff == ENABLE_ADDR |=> fn_enable_out == $past(wdata_ff))
        else $error("enable word not written");

    // The committed word sits in its cell one edge later
    a_commit_lands: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        commit && addr_ff != ENABLE_ADDR && !cfg_ld_in |=> cell_bus_rd == $past(wdata_ff))
        else $error("write not committed before ready");

    // Requests raised while busy are dropped, not queued
    a_busy_refused: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        req_in.en && state_ff == DRP_WAIT |=> $stable(addr_ff) && $stable(we_ff))
        else $error("request taken while busy");

    // Even back to back, a pulse is followed by two quiet cycles
    a_no_double_rdy: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        ready_out |=> s_quiet)
        else $error("second ready for one request");

    // Idle never carries a pulse
    a_idle_no_ready: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        state_ff == DRP_IDLE |-> !ready_out)
        else $error("ready while idle");
endmodule

/* inc/drp_pkg.sv */
// Package: constants and carrier types for the dynamic reconfiguration port
package drp_pkg;
    // ****************************************
    // Widths and timing
    // ****************************************
    localparam int ADDR_W      = 7;
    localparam int DATA_W      = 16;    // Clock-manager word width
    localparam int NUM_CELLS   = 128;
    localparam int WAIT_CYCLES = 2;     // Wait states before ready
    localparam int CNT_W       = 4;

    // ****************************************
    // Cell map
    // ****************************************
    localparam logic [ADDR_W-1:0] STATUS_ADDR = 7'h00;  // Read-only status word
    localparam logic [ADDR_W-1:0] ENABLE_ADDR = 7'h00;  // Write-only function enables
    localparam logic [DATA_W-1:0] CELL_RST    = 16'h0000;

    // Request carrier
    typedef struct packed {
        logic              en;
        logic              we;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } drp_req_t;

    typedef enum logic [1:0] {
        DRP_IDLE,
        DRP_WAIT,
        DRP_DONE
    } drp_state_t;
endpackage

/* hw/drp_cells.sv */
// Configuration cell array: flip-flop storage addressed by an index
`timescale 1ns/10ps
module drp_cells #(
    parameter int N = drp_pkg::NUM_CELLS,
    parameter int W = drp_pkg::DATA_W,
    parameter int A = drp_pkg::ADDR_W
) (
    input  wire logic                mclk_in,
    input  wire logic                rst_b_in,
    input  wire logic                wr_in,
    input  wire logic [A-1:0]        waddr_in,
    input  wire logic [W-1:0]        wdata_in,
    input  wire logic                ld_in,
    input  wire logic [A-1:0]        ldaddr_in,
    input  wire logic [W-1:0]        lddata_in,
    input  wire logic [A-1:0]        raddr_in,
    output logic      [W-1:0]        rdata_out,
    output logic      [N*W-1:0]      cells_out
);
    import drp_pkg::*;

    logic [W-1:0] mem_ff [N];

    // ****************************************
    // Storage
    // ****************************************
    // Reset stands in for bitstream load; config access port load wins over port
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            for (int i = 0; i < N; i++) mem_ff[i] <= CELL_RST;
        end else if (ld_in) begin
            mem_ff[ldaddr_in] <= lddata_in;
        end else if (wr_in) begin
            mem_ff[waddr_in] <= wdata_in;
        end
    end

    // Unregistered read path
    assign rdata_out = mem_ff[raddr_in];

    // Every cell drives the functional block directly
    always_comb begin
        for (int i = 0; i < N; i++) cells_out[i*W +: W] = mem_ff[i];
    end
endmodule

/* tb/drp_requester.sv */
// Requester model: fabric-side user logic that drives the port
`timescale 1ns/10ps
module drp_requester
    import drp_pkg::*;
(
    input  wire logic                       mclk_in,
    input  wire logic                       ready_in,
    input  wire logic [drp_pkg::DATA_W-1:0] rdata_in,
    output drp_pkg::drp_req_t               req_out
);
    int                  cyc     = 0;
    int                  rdy_cnt = 0;
    int                  lat     = 0;
    logic [DATA_W-1:0]   rd_cap  = 16'h0000;

    initial req_out = '0;

    // Read data is unregistered, so mid-cycle capture sees the same word
    always @(negedge mclk_in) begin
        cyc = cyc + 1;
        if (ready_in === 1'b1) begin
            rdy_cnt = rdy_cnt + 1;
            rd_cap  = rdata_in;
            lat     = cyc;
        end
    end

    // One-cycle request; released fields carry inverted junk
    task automatic issue(input logic we, input logic [ADDR_W-1:0] a,
                         input logic [DATA_W-1:0] d);
        @(posedge mclk_in);
        req_out <= '{en: 1'b1, we: we, addr: a, wdata: d};
        @(posedge mclk_in);
        cyc = 0;
        req_out <= '{en: 1'b0, we: ~we, addr: ~a, wdata: ~d};
    endtask
endmodule

/* tb/dynamic_reconfig_port_tb_top.sv */
// Testbench top: scenarios for the dynamic reconfiguration port
`timescale 1ns/10ps
module dynamic_reconfig_port_tb_top;
    import drp_pkg::*;
    logic                        mclk_in  = 1'b0;
    logic                        rst_b_in = 1'b0;
    logic                        ld       = 1'b0;
    logic [ADDR_W-1:0]           ld_addr  = 7'h00;
    logic [DATA_W-1:0]           ld_data  = 16'h0000;
    logic [DATA_W-1:0]           status   = 16'hbeef;
    logic [DATA_W-1:0]           rdata;
    logic                        ready;
    logic [DATA_W-1:0]           fn_en;
    logic [NUM_CELLS*DATA_W-1:0] cells;
    drp_req_t                    req;
    int                          n_fail   = 0;
    int                          compares = 0;
    int                          r0;

    always #25 mclk_in = ~mclk_in;

    drp_port #(.WAITS(WAIT_CYCLES)) dut_u (.mclk_in(mclk_in), .rst_b_in(rst_b_in),
        .req_in(req), .cfg_ld_in(ld), .cfg_ldaddr_in(ld_addr), .cfg_lddata_in(ld_data),
        .status_in(status), .rdata_out(rdata), .ready_out(ready),
        .fn_enable_out(fn_en), .cells_out(cells));

    drp_requester part_u (.mclk_in(mclk_in), .ready_in(ready), .rdata_in(rdata),
        .req_out(req));

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Bounded wait for the answer, then look for a stray second pulse
    task automatic op(input logic we, input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] d);
        int b;
        int k;
        b = part_u.rdy_cnt;
        k = 0;
        part_u.issue(we, a, d);
        while (part_u.rdy_cnt == b && k < 8) begin
            @(negedge mclk_in);
            k++;
        end
        check(part_u.lat, 32'h3);
        repeat (3) @(negedge mclk_in);
        check(part_u.rdy_cnt, b + 1);
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        repeat (20) @(posedge mclk_in);
        rst_b_in <= 1'b1;
        @(negedge mclk_in);
        check(ready, 32'h0);
        check(fn_en, 32'h0);
        check(cells[5*DATA_W +: DATA_W], 32'h0);
        op(1'b1, 7'h05, 16'ha5c3);
        check(cells[5*DATA_W +: DATA_W], 32'ha5c3);
        op(1'b0, 7'h05, 16'h0000);
        check(part_u.rd_cap, 32'ha5c3);
        // Idle lines now look like a write to 0x7a; nothing must happen
        r0 = part_u.rdy_cnt;
        repeat (10) @(negedge mclk_in);
        check(part_u.rdy_cnt, r0);
        check(cells[7'h7a*DATA_W +: DATA_W], 32'h0);
        // Second request raised inside the first one's ready cycle
        r0 = part_u.rdy_cnt;
        part_u.issue(1'b1, 7'h09, 16'h1234);
        @(posedge mclk_in);
        part_u.issue(1'b0, 7'h09, 16'h0000);
        repeat (6) @(negedge mclk_in);
        check(part_u.rdy_cnt, r0 + 2);
        check(part_u.rd_cap, 32'h1234);
        check(part_u.lat, 32'h3);
        // A request raised during the wait states is dropped
        r0 = part_u.rdy_cnt;
        part_u.issue(1'b1, 7'h0c, 16'h0c0c);
        part_u.issue(1'b1, 7'h0d, 16'h0d0d);
        repeat (6) @(negedge mclk_in);
        check(part_u.rdy_cnt, r0 + 1);
        check(cells[7'h0d*DATA_W +: DATA_W], 32'h0);
        check(cells[7'h0c*DATA_W +: DATA_W], 32'h0c0c);
        // Shared address: write-only enables, read-only status
        op(1'b1, 7'h00, 16'h00f0);
        check(fn_en, 32'h00f0);
        op(1'b0, 7'h00, 16'h0000);
        check(part_u.rd_cap, 32'hbeef);
        // Config access port rewrite, then read-modify-write of one byte
        @(posedge mclk_in);
        ld      <= 1'b1;
        ld_addr <= 7'h11;
        ld_data <= 16'h5a5a;
        @(posedge mclk_in);
        ld      <= 1'b0;
        op(1'b0, 7'h11, 16'h0000);
        check(part_u.rd_cap, 32'h5a5a);
        op(1'b1, 7'h11, {8'h3c, part_u.rd_cap[7:0]});
        op(1'b0, 7'h11, 16'h0000);
        check(part_u.rd_cap, 32'h3c5a);
        tally_and_finish();
    end

    // Whole run is near 100 cycles; twenty times that means a hang
    initial begin
        repeat (2000) @(posedge mclk_in);
        n_fail++;
        tally_and_finish();
    end
endmodule
